/* design/isw_bridge.sv */
// Top level: serial host slave driving a self-timed single-wire master
`timescale 1ns/1ns
// Summary of operation
// [R1] Runs line sequences alone after command
// [R2] Status and read data report results
// [R3] Two select pins set slave address
// [R4] External pullup control low during strong pullup
// [R5] Strong and active pullup share one driver
// [R6] Active pullup fires only on rising edges
// [R7] Standard or overdrive line timing
// [R8] Host port is serial slave, SCL oversampled by the system clock
// [R9] Host waits after power-up before talking
// [R10] Control output low exactly while strong pullup
// [R11] Busy flag set during line activity
// [R12] Standard slot ends within 65us; speed governs
// [R13] Answer only own address, ignore others
module isw_bridge #(
    parameter logic [15:0] RSTL_STD_CYC = isw_pkg::C_RSTL_STD,
    parameter logic [15:0] RSTH_STD_CYC = isw_pkg::C_RSTH_STD
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_0_i,
    input wire logic addr_select_1_i,
    input wire logic ow_i,
    output logic ow_o,
    output logic ow_oe_o,
    output logic ext_pullup_ctrl_n_o,
    output logic line_busy_flag_o
);
    typedef struct packed {
        logic [1:0] ow_s;
        logic ow_p;
        isw_pkg::isw_ow_st_t ost;
        isw_pkg::isw_kind_t kind;
        logic [15:0] cnt;
        logic [2:0] nb;
        logic [7:0] sh;
        logic smp;
        logic tdir;
        logic arm;
        logic [7:0] cmd;
        logic cmd_wait;
        logic active_pullup_enable;
        logic strong_pullup_enable;
        logic speed_select;
        logic spu_on;
        logic [7:0] apu_cnt;
        logic [7:0] stat;
        logic [7:0] rdata;
        logic [1:0] ptr;
        logic [7:0] tx;
        logic low;
        logic up;
        logic pctl_n;
    } isw_main_q_t;

    isw_main_q_t q;
    isw_main_q_t d;
    isw_pkg::isw_rx_t rx;

    // Speed-dependent timing choice
    function automatic logic [15:0] pick(input logic od, input logic [15:0] s, input logic [15:0] o);
        return od ? o : s;
    endfunction

    // ---------------------------------------------------------------
    // Host port
    // ---------------------------------------------------------------
    isw_i2c_slave u_slave (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_select_0_i(addr_select_0_i),
        .addr_select_1_i(addr_select_1_i),
        .tx_i(q.tx),
        .rx_o(rx),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );

    // ---------------------------------------------------------------
    // Command intake and line engine
    // ---------------------------------------------------------------
    always_comb begin
        logic rise;
        logic go_rst;
        logic go_slot;
        logic fin;
        logic dir;
        logic [15:0] lo;
        logic [15:0] rl;
        rise = 1'b0;
        go_rst = 1'b0;
        go_slot = 1'b0;
        fin = 1'b0;
        dir = 1'b0;
        lo = '0;
        rl = '0;
        d = q;
        d.ow_s = {q.ow_s[0], ow_i};
        d.ow_p = q.ow_s[1];
        rise = q.ow_s[1] & ~q.ow_p;
        d.stat[isw_pkg::ST_LL] = q.ow_s[1]; // R2
        if (q.apu_cnt != 8'h00) begin
            d.apu_cnt = q.apu_cnt - 8'h01;
        end
        // Presence and reset recovery edges are left to the resistor
        if (rise && q.active_pullup_enable && q.ost == isw_pkg::OW_SLOT) begin
            d.apu_cnt = isw_pkg::C_APU; // R6
        end

        // Commands arriving while the line is busy are dropped
        if (rx.valid && q.ost == isw_pkg::OW_IDLE) begin
            if (rx.first) begin
                d.cmd = rx.data;
                d.cmd_wait = 1'b0;
                case (rx.data)
                    isw_pkg::CMD_DEV_RST: begin
                        d.active_pullup_enable = 1'b0;
                        d.strong_pullup_enable = 1'b0;
                        d.speed_select = 1'b0;
                        d.spu_on = 1'b0; // R10
                        d.stat = '0;
                        d.stat[isw_pkg::ST_RST] = 1'b1;
                        d.ptr = isw_pkg::PTR_STAT;
                    end
                    isw_pkg::CMD_LINE_RST: go_rst = 1'b1;
                    isw_pkg::CMD_RD_BYTE: begin
                        go_slot = 1'b1;
                        d.kind = isw_pkg::K_BYTE;
                        d.sh = 8'hff;
                    end
                    default: d.cmd_wait = 1'b1;
                endcase
            end else if (q.cmd_wait) begin
                d.cmd_wait = 1'b0;
                case (q.cmd)
                    isw_pkg::CMD_SET_PTR: d.ptr = rx.data[1:0];
                    isw_pkg::CMD_WR_CFG: if (rx.data[7:4] == ~rx.data[3:0]) begin
                        d.active_pullup_enable = rx.data[isw_pkg::CF_APU];
                        d.strong_pullup_enable = rx.data[isw_pkg::CF_SPU];
                        d.speed_select = rx.data[isw_pkg::CF_SPD]; // R7
                        if (!rx.data[isw_pkg::CF_SPU]) begin
                            d.spu_on = 1'b0; // R10
                        end
                        d.stat[isw_pkg::ST_RST] = 1'b0;
                        d.ptr = isw_pkg::PTR_CFG;
                    end
                    isw_pkg::CMD_BIT: begin
                        go_slot = 1'b1;
                        d.kind = isw_pkg::K_BIT;
                        d.sh = {7'h00, rx.data[7]};
                    end
                    isw_pkg::CMD_WR_BYTE: begin
                        go_slot = 1'b1;
                        d.kind = isw_pkg::K_BYTE;
                        d.sh = rx.data;
                    end
                    isw_pkg::CMD_TRIPLET: begin
                        go_slot = 1'b1;
                        d.kind = isw_pkg::K_TRIP;
                        d.sh = 8'h01;
                        d.tdir = rx.data[7];
                    end
                    default: d.cmd_wait = 1'b0;
                endcase
            end
        end

        // Launch a line sequence; any strong pullup in force ends here
        if (go_rst || go_slot) begin
            d.ost = go_rst ? isw_pkg::OW_RST : isw_pkg::OW_SLOT; // R1
            d.cnt = '0;
            d.nb = '0;
            d.stat[isw_pkg::ST_BUSY] = 1'b1; // R11
            d.ptr = isw_pkg::PTR_STAT;
            d.arm = q.strong_pullup_enable & ~q.spu_on & go_slot & (d.kind != isw_pkg::K_TRIP);
            if (q.spu_on) begin
                d.spu_on = 1'b0; // R10
                d.strong_pullup_enable = 1'b0;
            end
            if (go_rst) begin
                d.stat[isw_pkg::ST_SD] = 1'b0;
                d.stat[isw_pkg::ST_PPD] = 1'b0;
            end
        end

        // Line sequencer; timing follows the speed bit throughout
        case (q.ost)
            isw_pkg::OW_RST: begin
                rl = pick(q.speed_select, RSTL_STD_CYC, isw_pkg::C_RSTL_OD); // R7
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == rl + pick(q.speed_select, isw_pkg::C_SI_STD, isw_pkg::C_SI_OD) && !q.ow_s[1]) begin
                    d.stat[isw_pkg::ST_SD] = 1'b1; // R2
                end
                if (q.cnt == rl + pick(q.speed_select, isw_pkg::C_MSP_STD, isw_pkg::C_MSP_OD) &&
                    !q.ow_s[1] && !q.stat[isw_pkg::ST_SD]) begin
                    d.stat[isw_pkg::ST_PPD] = 1'b1; // R2
                end
                if (q.cnt == rl + pick(q.speed_select, RSTH_STD_CYC, isw_pkg::C_RSTH_OD) - 16'h0001) begin
                    fin = 1'b1;
                end
            end
            isw_pkg::OW_SLOT: begin
                lo = q.sh[0] ? pick(q.speed_select, isw_pkg::C_W1L_STD, isw_pkg::C_W1L_OD)
                             : pick(q.speed_select, isw_pkg::C_W0L_STD, isw_pkg::C_W0L_OD);
                d.cnt = q.cnt + 16'h0001;
                if (q.cnt == pick(q.speed_select, isw_pkg::C_RDS_STD, isw_pkg::C_RDS_OD)) begin
                    d.smp = q.ow_s[1];
                end
                // Strong pullup takes over at the release of the last slot
                if (q.cnt == lo && q.arm && (q.kind == isw_pkg::K_BIT || q.nb == 3'h7)) begin
                    d.spu_on = 1'b1; // R4
                    d.arm = 1'b0;
                end
                if (q.cnt == pick(q.speed_select, isw_pkg::C_W0L_STD, isw_pkg::C_W0L_OD) +
                             pick(q.speed_select, isw_pkg::C_REC_STD, isw_pkg::C_REC_OD) - 16'h0001) begin // R12
                    d.cnt = '0;
                    d.nb = q.nb + 3'h1;
                    case (q.kind)
                        isw_pkg::K_BYTE: begin
                            d.sh = {q.smp, q.sh[7:1]};
                            if (q.nb == 3'h7) begin
                                d.rdata = {q.smp, q.sh[7:1]}; // R2
                                fin = 1'b1;
                            end
                        end
                        isw_pkg::K_BIT: begin
                            d.stat[isw_pkg::ST_SBR] = q.smp;
                            fin = 1'b1;
                        end
                        isw_pkg::K_TRIP: begin
                            if (q.nb == 3'h0) begin
                                d.stat[isw_pkg::ST_SBR] = q.smp;
                            end else if (q.nb == 3'h1) begin
                                // Disagreeing bits decide; both zero use the host's choice
                                dir = (q.stat[isw_pkg::ST_SBR] != q.smp) ? q.stat[isw_pkg::ST_SBR] : q.tdir;
                                d.stat[isw_pkg::ST_TSB] = q.smp;
                                d.stat[isw_pkg::ST_DIR] = dir; // R2
                                d.sh = {7'h00, dir};
                            end else begin
                                fin = 1'b1;
                            end
                        end
                        default: fin = 1'b1;
                    endcase
                end
            end
            default: d.cnt = '0;
        endcase
        if (fin) begin
            d.ost = isw_pkg::OW_IDLE;
            d.stat[isw_pkg::ST_BUSY] = 1'b0; // R11
        end

        // Pin drive taken from the next state so outputs stay registered
        d.low = (d.ost == isw_pkg::OW_RST && d.cnt < pick(d.speed_select, RSTL_STD_CYC, isw_pkg::C_RSTL_OD)) ||
                (d.ost == isw_pkg::OW_SLOT && d.cnt < (d.sh[0] ?
                    pick(d.speed_select, isw_pkg::C_W1L_STD, isw_pkg::C_W1L_OD) :
                    pick(d.speed_select, isw_pkg::C_W0L_STD, isw_pkg::C_W0L_OD)));
        d.up = (d.apu_cnt != 8'h00 || d.spu_on) && !d.low; // R5
        d.pctl_n = ~d.spu_on; // R4 R10
        case (d.ptr)
            isw_pkg::PTR_DATA: d.tx = d.rdata;
            isw_pkg::PTR_CFG: d.tx = {4'h0, d.speed_select, d.strong_pullup_enable, 1'b0, d.active_pullup_enable};
            default: d.tx = d.stat;
        endcase
    end

    // State register; power-up reports the reset flag
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.stat <= 8'h10;
            q.pctl_n <= 1'b1;
            q.tx <= 8'h10;
        end else begin
            q <= d;
        end
    end

    assign ow_o = q.up;
    assign ow_oe_o = q.up | q.low;
    assign ext_pullup_ctrl_n_o = q.pctl_n;
    assign line_busy_flag_o = q.stat[isw_pkg::ST_BUSY];
endmodule

/* design/isw_i2c_slave.sv */
// Host-side serial slave: byte receive, acknowledge and read-back
`timescale 1ns/1ns
module isw_i2c_slave (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic addr_select_0_i,
    input wire logic addr_select_1_i,
    input wire logic [7:0] tx_i,
    output isw_pkg::isw_rx_t rx_o,
    output logic sda_o,
    output logic sda_oe_o
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] ad0_s;
        logic [1:0] ad1_s;
        logic scl_p;
        logic sda_p;
        isw_pkg::isw_i2c_st_t st;
        logic [3:0] n;
        logic [7:0] sh;
        logic addr;
        logic rd;
        logic first;
        logic oe;
        logic sdo;
        isw_pkg::isw_rx_t rx;
    } isw_i2c_q_t;

    isw_i2c_q_t q;
    isw_i2c_q_t d;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Only the second sync stage is read, so SCL runs fully asynchronous
    always_comb begin
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic match;
        scl = q.scl_s[1];
        sda = q.sda_s[1];
        rise = scl & ~q.scl_p;
        fall = ~scl & q.scl_p;
        match = (q.sh[6:0] == {isw_pkg::ADDR_BASE, q.ad1_s[1], q.ad0_s[1]}); // R3
        d = q;
        d.rx.valid = 1'b0;
        d.sdo = 1'b0;
        d.scl_s = {q.scl_s[0], scl_i};
        d.sda_s = {q.sda_s[0], sda_i};
        d.ad0_s = {q.ad0_s[0], addr_select_0_i};
        d.ad1_s = {q.ad1_s[0], addr_select_1_i};
        d.scl_p = scl;
        d.sda_p = sda;
        if (scl && q.scl_p && q.sda_p && !sda) begin
            // Start or repeated start
            d.st = isw_pkg::I_RX;
            d.n = 4'h0;
            d.addr = 1'b1;
            d.oe = 1'b0;
        end else if (scl && q.scl_p && !q.sda_p && sda) begin
            // Stop
            d.st = isw_pkg::I_IDLE;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                isw_pkg::I_RX: if (rise) begin // R8
                    d.sh = {q.sh[6:0], sda};
                    d.n = q.n + 4'h1;
                    if (q.n == 4'h7) begin
                        if (q.addr) begin
                            // Foreign addresses are left alone entirely
                            d.st = match ? isw_pkg::I_ACKW : isw_pkg::I_IDLE; // R13
                            d.rd = sda;
                            d.first = 1'b1;
                        end else begin
                            d.rx.valid = 1'b1;
                            d.rx.first = q.first;
                            d.rx.data = {q.sh[6:0], sda};
                            d.first = 1'b0;
                            d.st = isw_pkg::I_ACKW;
                        end
                    end
                end
                isw_pkg::I_ACKW: if (fall) begin
                    d.oe = 1'b1;
                    d.st = isw_pkg::I_ACK;
                end
                isw_pkg::I_ACK: if (fall) begin
                    d.addr = 1'b0;
                    d.n = 4'h1;
                    if (q.rd) begin
                        d.sh = tx_i;
                        d.oe = ~tx_i[7];
                        d.st = isw_pkg::I_TX;
                    end else begin
                        d.n = 4'h0;
                        d.oe = 1'b0;
                        d.st = isw_pkg::I_RX;
                    end
                end
                isw_pkg::I_TX: if (fall) begin
                    d.sh = {q.sh[6:0], 1'b0};
                    d.oe = ~q.sh[6];
                    d.n = q.n + 4'h1;
                    if (q.n == 4'h8) begin
                        d.oe = 1'b0;
                        d.st = isw_pkg::I_RACK;
                    end
                end
                // Master ack means another byte follows from the same pointer
                isw_pkg::I_RACK: if (rise) begin
                    d.st = sda ? isw_pkg::I_IDLE : isw_pkg::I_ACK;
                end
                default: d.st = isw_pkg::I_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.scl_s <= 2'h3;
            q.sda_s <= 2'h3;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rx_o = q.rx;
    assign sda_o = q.sdo;
    assign sda_oe_o = q.oe;
endmodule

/* design/isw_pkg.sv */
// Shared constants and types for the serial-to-single-wire bridge
package isw_pkg;
    // ---------------------------------------------------------------
    // Clock and time conversion
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 25;

    // Least times round up to whole clock cycles
    function automatic int cyc_up(input int t_ns);
        return (t_ns * CLK_MHZ + 999) / 1000;
    endfunction

    // Single-wire times in ns, standard and overdrive; one active pullup time for both speeds
    localparam int T_RSTL_STD_NS = 600000;
    localparam int T_RSTL_OD_NS = 72000;
    localparam int T_RSTH_STD_NS = 584000;
    localparam int T_RSTH_OD_NS = 74000;
    localparam int T_MSP_STD_NS = 70000;
    localparam int T_MSP_OD_NS = 7500;
    localparam int T_SI_STD_NS = 8000;
    localparam int T_SI_OD_NS = 750;
    localparam int T_W0L_STD_NS = 60000;
    localparam int T_W0L_OD_NS = 7500;
    localparam int T_W1L_STD_NS = 6000;
    localparam int T_W1L_OD_NS = 1000;
    localparam int T_RDS_STD_NS = 13000;
    localparam int T_RDS_OD_NS = 1500;
    localparam int T_REC_STD_NS = 5000;
    localparam int T_REC_OD_NS = 3000;
    localparam int T_APU_NS = 2500;

    // Cycle counts
    localparam logic [15:0] C_RSTL_STD = 16'(cyc_up(T_RSTL_STD_NS));
    localparam logic [15:0] C_RSTL_OD = 16'(cyc_up(T_RSTL_OD_NS));
    localparam logic [15:0] C_RSTH_STD = 16'(cyc_up(T_RSTH_STD_NS));
    localparam logic [15:0] C_RSTH_OD = 16'(cyc_up(T_RSTH_OD_NS));
    localparam logic [15:0] C_MSP_STD = 16'(cyc_up(T_MSP_STD_NS));
    localparam logic [15:0] C_MSP_OD = 16'(cyc_up(T_MSP_OD_NS));
    localparam logic [15:0] C_SI_STD = 16'(cyc_up(T_SI_STD_NS));
    localparam logic [15:0] C_SI_OD = 16'(cyc_up(T_SI_OD_NS));
    localparam logic [15:0] C_W0L_STD = 16'(cyc_up(T_W0L_STD_NS));
    localparam logic [15:0] C_W0L_OD = 16'(cyc_up(T_W0L_OD_NS));
    localparam logic [15:0] C_W1L_STD = 16'(cyc_up(T_W1L_STD_NS));
    localparam logic [15:0] C_W1L_OD = 16'(cyc_up(T_W1L_OD_NS));
    localparam logic [15:0] C_RDS_STD = 16'(cyc_up(T_RDS_STD_NS));
    localparam logic [15:0] C_RDS_OD = 16'(cyc_up(T_RDS_OD_NS));
    localparam logic [15:0] C_REC_STD = 16'(cyc_up(T_REC_STD_NS));
    localparam logic [15:0] C_REC_OD = 16'(cyc_up(T_REC_OD_NS));
    localparam logic [7:0] C_APU = 8'(cyc_up(T_APU_NS));

    // ---------------------------------------------------------------
    // Host port: slave address and commands
    // ---------------------------------------------------------------
    localparam logic [4:0] ADDR_BASE = 5'h0c;
    localparam logic [7:0] CMD_DEV_RST = 8'h01;
    localparam logic [7:0] CMD_SET_PTR = 8'h02;
    localparam logic [7:0] CMD_WR_CFG = 8'h03;
    localparam logic [7:0] CMD_LINE_RST = 8'h04;
    localparam logic [7:0] CMD_BIT = 8'h05;
    localparam logic [7:0] CMD_WR_BYTE = 8'h06;
    localparam logic [7:0] CMD_RD_BYTE = 8'h07;
    localparam logic [7:0] CMD_TRIPLET = 8'h08;

    // Read pointer codes
    localparam logic [1:0] PTR_STAT = 2'h0;
    localparam logic [1:0] PTR_DATA = 2'h1;
    localparam logic [1:0] PTR_CFG = 2'h2;

    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_PPD = 1;
    localparam int ST_SD = 2;
    localparam int ST_LL = 3;
    localparam int ST_RST = 4;
    localparam int ST_SBR = 5;
    localparam int ST_TSB = 6;
    localparam int ST_DIR = 7;

    // Configuration bit positions
    localparam int CF_APU = 0;
    localparam int CF_SPU = 2;
    localparam int CF_SPD = 3;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum {I_IDLE, I_RX, I_ACKW, I_ACK, I_TX, I_RACK} isw_i2c_st_t;
    typedef enum {OW_IDLE, OW_RST, OW_SLOT} isw_ow_st_t;
    typedef enum {K_BIT, K_BYTE, K_TRIP} isw_kind_t;

    // Received host byte, valid for one cycle
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } isw_rx_t;
endpackage

/* verif/isw_bridge_props.sv */
// Bridge port assertions
`timescale 1ns/1ns
module isw_bridge_props #(
    parameter logic [15:0] RSTL_STD_CYC = 16'h3a98
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic ow_i,
    input wire logic ow_o,
    input wire logic ow_oe_o,
    input wire logic ext_pullup_ctrl_n_o,
    input wire logic line_busy_flag_o
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [15:0] lo_q;
    logic [3:0] hi_q;
    wire pu = ow_oe_o && ow_o;
    // Low-drive length; cycles since line low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_q <= 16'h0;
            hi_q <= 4'hf;
        end else begin
            lo_q <= (ow_oe_o && !ow_o) ? lo_q + 16'h1 : 16'h0;
            hi_q <= !ow_i ? 4'h0 : ((hi_q == 4'hf) ? hi_q : hi_q + 4'h1);
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_sda_open_drain: assert property (!sda_o) else $error("sda driven high");
    a_sda_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("sda moved");
    a_ext_means_strong: assert property (!ext_pullup_ctrl_n_o |-> pu) else $error("ext no pullup");
    a_ext_starts_busy: assert property ($fell(ext_pullup_ctrl_n_o) |-> line_busy_flag_o) else $error("idle");
    a_low_needs_busy: assert property (ow_oe_o && !ow_o |-> line_busy_flag_o) else $error("low idle");
    a_low_bounded: assert property (lo_q <= RSTL_STD_CYC) else $error("low too long");
    a_apu_on_rise: assert property ($rose(pu) && ext_pullup_ctrl_n_o |-> hi_q < 4'h8) else $error("no rise");
    a_apu_holds: assert property ($rose(pu) && ext_pullup_ctrl_n_o |=> pu [*8]) else $error("pullup short");
    c_strong: cover property ($fell(ext_pullup_ctrl_n_o));
    c_ack: cover property ($rose(sda_oe_o));
    c_apu: cover property ($rose(pu) && ext_pullup_ctrl_n_o);
endmodule
bind isw_bridge isw_bridge_props #(.RSTL_STD_CYC(RSTL_STD_CYC)) isw_bridge_props_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .ow_i(ow_i), .ow_o(ow_o), .ow_oe_o(ow_oe_o), .ext_pullup_ctrl_n_o(ext_pullup_ctrl_n_o),
    .line_busy_flag_o(line_busy_flag_o));

/* verif/isw_line_model.sv */
// Single-wire slave model
`timescale 1ns/1ns
module isw_line_model (
    input wire logic clock_i,
    input wire logic line_i,
    input wire logic od_i,
    input wire logic rd_mode_i,
    input wire logic [7:0] tx_i,
    output logic pd_o,
    output logic [7:0] rx_o
);
    int n, k = 0;
    // Pulls low only; the bench resistor pulls high
    initial begin
        pd_o = 1'b0;
        rx_o = 8'h00;
        forever begin
            @(negedge line_i);
            if (rd_mode_i) begin
                // A zero is held past the sample point
                pd_o = !tx_i[k];
                repeat (od_i ? 60 : 500) @(posedge clock_i);
                pd_o = 1'b0;
                k = (k + 1) % 8;
            end else begin
                for (n = 0; !line_i; n++) @(posedge clock_i);
                if (n > 1700) begin
                    repeat (600) @(posedge clock_i);
                    pd_o = 1'b1;
                    repeat (1800) @(posedge clock_i);
                    pd_o = 1'b0;
                end else begin
                    // Split between write-one and write-zero lows at each speed
                    rx_o = {n < (od_i ? 100 : 800), rx_o[7:1]};
                end
            end
        end
    end
endmodule

/* verif/test_isw_bridge.sv */
// Bridge bench
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module test_isw_bridge;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic scl = 1'b1, sda = 1'b1, od = 1'b0, rdm = 1'b0;
    logic [1:0] ad = 2'h0;
    logic sda_o, sda_oe_o, ow_o, ow_oe_o, ext_n, busy, pd, a;
    logic [7:0] rx, d;
    int fail_count = 0, check_count = 0, cyc = 0, n;
    wire sda_w = sda && !(sda_oe_o && !sda_o);
    wire ow_w = !((ow_oe_o && !ow_o) || pd);
    wire [6:0] me = {isw_pkg::ADDR_BASE, ad};
    always #20 clock_i = !clock_i;
    isw_bridge #(.RSTL_STD_CYC(16'h07d0), .RSTH_STD_CYC(16'h0bb8)) isw_bridge_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .addr_select_0_i(ad[0]), .addr_select_1_i(ad[1]), .ow_i(ow_w), .ow_o(ow_o), .ow_oe_o(ow_oe_o),
        .ext_pullup_ctrl_n_o(ext_n), .line_busy_flag_o(busy));
    isw_line_model isw_line_model_i (.clock_i(clock_i), .line_i(ow_w), .od_i(od), .rd_mode_i(rdm),
        .tx_i(8'h96), .pd_o(pd), .rx_o(rx));
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    // One host bit, eight clocks
    task automatic bit_io(input logic b);
        sda <= b;
        tick(3);
        scl <= 1'b1;
        tick(4);
        a = sda_w;
        scl <= 1'b0;
        tick(1);
    endtask
    // START, address, nb bytes, STOP; a is the ack
    task automatic xfer(input logic [7:0] adr, input logic [7:0] c, input logic [7:0] v, input int nb);
        logic k;
        sda <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(1);
        for (int j = 0; j <= nb; j++) begin
            for (int i = 7; i >= 0; i--) bit_io(j == 0 ? adr[i] : (j == 1 ? c[i] : v[i]));
            bit_io(1'b1);
            if (j == 0) k = !a;
        end
        if (adr[0]) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(1'b1);
                d[i] = a;
            end
            bit_io(1'b1);
        end
        a = k;
        sda <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda <= 1'b1;
        tick(8);
    endtask
    task automatic wait_idle();
        for (n = 0; busy !== 1'b0 && n < 20000; n++) tick(1);
    endtask
    task automatic rd();
        xfer({me, 1'b1}, 8'h00, 8'h00, 0);
    endtask
    task automatic wr(input logic [7:0] c, v);
        xfer({me, 1'b0}, c, v, 2);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        tick(8);
        rst_n_i <= 1'b1;
        tick(2500);
        `CHK("ext_n", 1'b1, ext_n)
        rd();
        `CHK("status", 8'h18, d)
        // Own address acked, neighbour's not
        for (int p = 0; p < 4; p++) begin
            ad <= 2'(p);
            tick(4);
            xfer({isw_pkg::ADDR_BASE, 2'(p) ^ 2'h1, 1'b0}, 8'h00, 8'h00, 0);
            `CHK("nack", 1'b0, a)
            xfer({isw_pkg::ADDR_BASE, 2'(p), 1'b0}, 8'h00, 8'h00, 0);
            `CHK("ack", 1'b1, a)
        end
        xfer({me, 1'b0}, isw_pkg::CMD_LINE_RST, 8'h00, 1);
        `CHK("busy", 1'b1, busy)
        wait_idle();
        rd();
        `CHK("presence", 2'h2, d[1:0])
        wr(isw_pkg::CMD_WR_CFG, 8'he1);
        wr(isw_pkg::CMD_WR_BYTE, 8'ha5);
        wait_idle();
        `CHK("std_time", 1'b1, n <= 8 * 1625)
        `CHK("rx", 8'ha5, rx)
        rdm <= 1'b1;
        xfer({me, 1'b0}, isw_pkg::CMD_RD_BYTE, 8'h00, 1);
        wait_idle();
        rdm <= 1'b0;
        wr(isw_pkg::CMD_SET_PTR, {6'h00, isw_pkg::PTR_DATA});
        rd();
        `CHK("rdata", 8'h96, d)
        wr(isw_pkg::CMD_WR_CFG, 8'hb4);
        wr(isw_pkg::CMD_WR_BYTE, 8'h3c);
        wait_idle();
        `CHK("ext_on", 1'b0, ext_n)
        `CHK("pullup", 2'h3, {ow_oe_o, ow_o})
        wr(isw_pkg::CMD_SET_PTR, {6'h00, isw_pkg::PTR_CFG});
        rd();
        `CHK("cfg_spu", 8'h04, d)
        wr(isw_pkg::CMD_WR_CFG, 8'hf0);
        `CHK("ext_off", 1'b1, ext_n)
        rd();
        `CHK("cfg_off", 8'h00, d)
        wr(isw_pkg::CMD_WR_CFG, 8'h78);
        od <= 1'b1;
        wr(isw_pkg::CMD_WR_BYTE, 8'h5a);
        wait_idle();
        `CHK("od_time", 1'b1, n <= 8 * 263)
        `CHK("rx_od", 8'h5a, rx)
        rd();
        `CHK("status", 8'h0a, d)
        stop_test();
    end
endmodule
